// File: design/ace_top.sv
`timescale 1ns/1ps
`default_nettype none
module ace_top #(
  parameter int NUM = ace_pkg::NUM_COMP,
  parameter int STARTUP = ace_pkg::STARTUP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Primary control
  input wire logic ctrl_wr,
  input wire ace_pkg::ace_ctrl_t ctrl_wdata,
  output ace_pkg::ace_ctrl_t ctrl_rdata,
  // Event control
  input wire logic evt_wr,
  input wire logic [ace_pkg::EVT_W-1:0] evt_wdata,
  output logic [ace_pkg::EVT_W-1:0] event_control_reg,
  // Debug control
  input wire logic dbg_wr,
  input wire logic [7:0] dbg_wdata,
  output logic [7:0] debug_reg,
  // Comparator configuration
  input wire logic [NUM-1:0] cfg_wr,
  input wire ace_pkg::ace_cfg_t [NUM-1:0] cfg_wdata,
  output ace_pkg::ace_cfg_t [NUM-1:0] comparator_config_reg,
  // Single-shot start
  input wire logic [NUM-1:0] start_req,
  // Analog comparator decisions from pins
  input wire logic [NUM-1:0] cmp_in,
  // Status
  output logic [NUM-1:0] result,
  output logic [NUM-1:0] result_ready,
  output logic [NUM-1:0] comp_active,
  output logic doubler_on
);
  ace_pkg::ace_ctrl_t ctrl, next_ctrl;
  logic [ace_pkg::EVT_W-1:0] next_evt;
  logic [7:0] next_dbg;
  ace_pkg::ace_cfg_t [NUM-1:0] next_cfg;
  logic [NUM-1:0] sync1, sync2;
  logic swr;

  assign swr = ctrl_wr && ctrl_wdata.soft_reset_bit;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_evt = event_control_reg;
    next_dbg = debug_reg;
    next_ctrl.soft_reset_bit = 1'b0;
    if (ctrl_wr) begin
      next_ctrl.enable = ctrl_wdata.enable;
      next_ctrl.doubler_bypass_bit = ctrl_wdata.doubler_bypass_bit;
    end
    if (evt_wr && !ctrl.enable) begin
      next_evt = evt_wdata;
    end
    if (dbg_wr) begin
      next_dbg = dbg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= '0;
      event_control_reg <= ace_pkg::EVT_RST;
      debug_reg <= ace_pkg::DEBUG_RST;
    end else if (clk_en) begin
      if (swr) begin
        ctrl <= '0;
        event_control_reg <= ace_pkg::EVT_RST;
        debug_reg <= next_dbg;
      end else begin
        ctrl <= next_ctrl;
        event_control_reg <= next_evt;
        debug_reg <= next_dbg;
      end
    end
  end

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en) begin
      sync1 <= cmp_in;
      sync2 <= sync1;
    end
  end

  // ----------------------------------------
  // Per-comparator configuration and channel
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_ch
      always_comb begin
        next_cfg[i] = comparator_config_reg[i];
        if (cfg_wr[i]) begin
          if (comparator_config_reg[i].enable) begin
            next_cfg[i].enable = cfg_wdata[i].enable;
          end else begin
            next_cfg[i] = cfg_wdata[i];
          end
        end
      end

      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          comparator_config_reg[i] <= ace_pkg::CFG_RST;
        end else if (clk_en) begin
          comparator_config_reg[i] <= swr ? ace_pkg::CFG_RST : next_cfg[i];
        end
      end

      ace_channel #(
        .STARTUP(STARTUP),
        .EXTRA(ace_pkg::DOUBLER_EXTRA_CYC)
      ) u_ch (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .soft_clr(swr),
        .active(ctrl.enable && comparator_config_reg[i].enable),
        .single_shot(comparator_config_reg[i].single_shot),
        .doubler_on(!ctrl.doubler_bypass_bit),
        .start_req(start_req[i]),
        .raw_cmp(sync2[i]),
        .result(result[i]),
        .result_ready(result_ready[i]),
        .ch_on(comp_active[i])
      );
    end
  endgenerate

  assign ctrl_rdata = ctrl;
  assign doubler_on = !ctrl.doubler_bypass_bit;

endmodule : ace_top
`default_nettype wire

// File: design/ace_pkg.sv
// Notes on behaviour
// - Event settings frozen while unit enabled
// - Config fields frozen while comparator enabled
// - Global enable bit turns unit on/off
// - Comparator runs only with both enables set
// - Global disable keeps individual enable bits
// - Soft reset restores registers except debug, disables
// - Each channel continuous or single-shot by select
// - Timed start-up wait after enable before ready
// - Result reported unavailable during start-up
// - Doubler bypass bit disables voltage doubler
// - Config holds deadband, speed, irq, inputs, filter
// - Result one when plus exceeds minus input
package ace_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYC_RAW = (STARTUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int STARTUP_CYC = (STARTUP_CYC_RAW < 1) ? 1 : STARTUP_CYC_RAW;
  localparam int DOUBLER_EXTRA_NS = 2000;
  localparam int DOUBLER_EXTRA_CYC = (DOUBLER_EXTRA_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int NUM_COMP = 2;

  // ----------------------------------------
  // Field widths and reset values
  // ----------------------------------------
  localparam int EVT_W = 4;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [1:0] DEADBAND_RST = 2'h0;
  localparam logic [1:0] SPEED_RST = 2'h0;
  localparam logic [1:0] IRQ_SEL_RST = 2'h0;
  localparam logic [2:0] PLUS_SEL_RST = 3'h0;
  localparam logic [2:0] MINUS_SEL_RST = 3'h0;
  localparam logic [2:0] FILTER_RST = 3'h0;
  localparam logic [7:0] DEBUG_RST = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic enable;
    logic single_shot;
    logic [1:0] input_deadband_select;
    logic [1:0] speed_select;
    logic [1:0] irq_source_select;
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
    logic [2:0] filter_length_select;
  } ace_cfg_t;

  localparam ace_cfg_t CFG_RST = '{1'b0, 1'b0, DEADBAND_RST, SPEED_RST, IRQ_SEL_RST,
                                    PLUS_SEL_RST, MINUS_SEL_RST, FILTER_RST};

  typedef struct packed {
    logic enable;
    logic soft_reset_bit;
    logic doubler_bypass_bit;
  } ace_ctrl_t;

  typedef enum logic [3:0] {
    CH_OFF = 4'h1,
    CH_STARTUP = 4'h2,
    CH_RUN = 4'h4,
    CH_HOLD = 4'h8
  } ace_ch_state_t;

endpackage : ace_pkg

// File: design/ace_channel.sv
`timescale 1ns/1ps
`default_nettype none
module ace_channel #(
  parameter int STARTUP = ace_pkg::STARTUP_CYC,
  parameter int EXTRA = ace_pkg::DOUBLER_EXTRA_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic soft_clr,
  // Control
  input wire logic active,
  input wire logic single_shot,
  input wire logic doubler_on,
  input wire logic start_req,
  // Analog front end (synchronised)
  input wire logic raw_cmp,
  // Result
  output logic result,
  output logic result_ready,
  output logic ch_on
);
  localparam logic [ace_pkg::CNT_W-1:0] LOAD_BASE = ace_pkg::CNT_W'(STARTUP);
  localparam logic [ace_pkg::CNT_W-1:0] LOAD_EXT = ace_pkg::CNT_W'(STARTUP + EXTRA);

  ace_pkg::ace_ch_state_t state, next_state;
  logic [ace_pkg::CNT_W-1:0] cnt, next_cnt;
  logic next_result;
  logic pend, next_pend;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_result = result;
    next_pend = pend | start_req;
    case (state)
      ace_pkg::CH_OFF: begin
        next_pend = 1'b0;
        if (active) begin
          next_state = ace_pkg::CH_STARTUP;
          next_cnt = doubler_on ? LOAD_EXT : LOAD_BASE;
        end
      end
      ace_pkg::CH_STARTUP: begin
        if (cnt <= 1) begin
          next_state = single_shot ? ace_pkg::CH_HOLD : ace_pkg::CH_RUN;
          next_cnt = '0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ace_pkg::CH_RUN: begin
        next_result = raw_cmp;
        if (single_shot) begin
          next_state = ace_pkg::CH_HOLD;
        end
      end
      ace_pkg::CH_HOLD: begin
        if (pend || start_req) begin
          next_result = raw_cmp;
          next_pend = 1'b0;
        end
        if (!single_shot) begin
          next_state = ace_pkg::CH_RUN;
        end
      end
      default: begin
        next_state = ace_pkg::CH_OFF;
      end
    endcase
    if (!active) begin
      next_state = ace_pkg::CH_OFF;
      next_result = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst || (clk_en && soft_clr)) begin
      state <= ace_pkg::CH_OFF;
      cnt <= '0;
      result <= 1'b0;
      pend <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      result <= next_result;
      pend <= next_pend;
    end
  end

  assign result_ready = (state == ace_pkg::CH_RUN) || (state == ace_pkg::CH_HOLD);
  assign ch_on = (state != ace_pkg::CH_OFF);

endmodule : ace_channel
`default_nettype wire

// File: test/ace_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ace_sva #(
  parameter int NUM = 2,
  parameter int STARTUP = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Writes and pins
  input wire logic ctrl_wr,
  input wire ace_pkg::ace_ctrl_t ctrl_wdata,
  input wire logic evt_wr,
  input wire logic [NUM-1:0] cfg_wr,
  input wire logic [NUM-1:0] cmp_in,
  // State
  input wire ace_pkg::ace_ctrl_t ctrl_rdata,
  input wire logic [ace_pkg::EVT_W-1:0] event_control_reg,
  input wire ace_pkg::ace_cfg_t [NUM-1:0] comparator_config_reg,
  input wire logic [NUM-1:0] result,
  input wire logic [NUM-1:0] result_ready,
  input wire logic [NUM-1:0] comp_active
);
  // --------------------
  // Checks
  // --------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic swr;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  assign swr = ctrl_wr && clk_en && ctrl_wdata.soft_reset_bit;
  always_comb begin
    next_cnt = !comp_active[0] ? 8'h00 : (clk_en && cnt != 8'hff) ? cnt + 8'h01 : cnt;
  end
  always_ff @(posedge core_clk) begin
    cnt <= nrst ? next_cnt : 8'h00;
  end
  sequence s_off; ##1 !comp_active[0]; endsequence
  property p_evt; evt_wr && clk_en && ctrl_rdata.enable && !swr |=> $stable(event_control_reg); endproperty
  a_evt: assert property (p_evt) else $error("event lock broken");
  property p_cfg; cfg_wr[0] && clk_en && comparator_config_reg[0].enable && !swr
    |=> $stable(comparator_config_reg[0][15:0]); endproperty
  a_cfg: assert property (p_cfg) else $error("config lock broken");
  property p_en; ctrl_wr && clk_en && !swr |=> ctrl_rdata.enable == $past(ctrl_wdata.enable); endproperty
  a_en: assert property (p_en) else $error("enable not taken");
  property p_both; comp_active[0] |-> $past(ctrl_rdata.enable && comparator_config_reg[0].enable); endproperty
  a_both: assert property (p_both) else $error("active without enables");
  property p_keep; ctrl_wr && clk_en && !ctrl_wdata.enable && !swr && !cfg_wr[0]
    |=> $stable(comparator_config_reg[0].enable) ##0 s_off; endproperty
  a_keep: assert property (p_keep) else $error("disable wrong");
  property p_swr; swr |=> ctrl_rdata == '0 && event_control_reg == ace_pkg::EVT_RST
    && comparator_config_reg[0] == ace_pkg::CFG_RST ##0 s_off; endproperty
  a_swr: assert property (p_swr) else $error("soft reset wrong");
  property p_rdy; result_ready[0] |-> cnt >= STARTUP; endproperty
  a_rdy: assert property (p_rdy) else $error("ready too early");
  property p_cont; result_ready[0] && $past(result_ready[0], 3) && !comparator_config_reg[0].single_shot
    |-> result[0] == $past(cmp_in[0], 3); endproperty
  a_cont: assert property (p_cont) else $error("result not following");
endmodule : ace_sva
bind ace_top ace_sva #(.NUM(NUM), .STARTUP(STARTUP)) sva_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .evt_wr(evt_wr), .cfg_wr(cfg_wr), .cmp_in(cmp_in),
  .ctrl_rdata(ctrl_rdata), .event_control_reg(event_control_reg), .comparator_config_reg(comparator_config_reg),
  .result(result), .result_ready(result_ready), .comp_active(comp_active));
`default_nettype wire

// File: test/ace_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ace_partner (
  // Pin voltages, 12 bits per channel
  input wire logic [23:0] plus_mv,
  input wire logic [23:0] minus_mv,
  // Decisions
  output logic [1:0] cmp_in
);
  // --------------------
  // Analog model
  // --------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_in[i] = plus_mv[i*12 +: 12] > minus_mv[i*12 +: 12];
    end
  end
endmodule : ace_partner
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // --------------------
  // Bench
  // --------------------
  localparam int ST = 2;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic ctrl_wr = 1'b0;
  logic evt_wr = 1'b0;
  logic dbg_wr = 1'b0;
  logic [1:0] cfg_wr = 2'h0;
  ace_pkg::ace_ctrl_t ctrl_wdata = '0;
  ace_pkg::ace_ctrl_t ctrl_q;
  logic [3:0] evt_wdata = 4'h0;
  logic [3:0] evt_q;
  logic [7:0] dbg_wdata = 8'h00;
  logic [7:0] dbg_q;
  ace_pkg::ace_cfg_t [1:0] cfg_wdata = '0;
  ace_pkg::ace_cfg_t [1:0] cfg_q;
  logic [1:0] start_req = 2'h0;
  logic [1:0] cmp_in;
  logic [23:0] plus_mv = 24'h000000;
  logic [23:0] minus_mv = 24'h000000;
  logic [1:0] res;
  logic [1:0] rdy;
  logic [1:0] act;
  logic dbl;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  ace_top #(.NUM(2), .STARTUP(ST)) dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_q), .evt_wr(evt_wr),
    .evt_wdata(evt_wdata), .event_control_reg(evt_q), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata),
    .debug_reg(dbg_q), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .comparator_config_reg(cfg_q),
    .start_req(start_req), .cmp_in(cmp_in), .result(res), .result_ready(rdy),
    .comp_active(act), .doubler_on(dbl));
  ace_partner model_u (.plus_mv(plus_mv), .minus_mv(minus_mv), .cmp_in(cmp_in));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask : tick
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int k, input logic [16:0] d, input int ch);
    ctrl_wdata = d[2:0];
    evt_wdata = d[3:0];
    dbg_wdata = d[7:0];
    cfg_wdata[ch] = d;
    {cfg_wr[ch], dbg_wr, evt_wr, ctrl_wr} = 4'(4'h1 << k);
    tick(1);
    {cfg_wr, dbg_wr, evt_wr, ctrl_wr} = 5'h00;
    tick(1);
  endtask : wr
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_rdy(input int ch);
    n = 0;
    while (rdy[ch] !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_rdy
  initial begin
    tick(3);
    nrst = 1'b1;
    chk({ctrl_q, evt_q, dbg_q, dbl}, {3'h0, ace_pkg::EVT_RST, ace_pkg::DEBUG_RST, 1'b1});
    wr(1, 17'h0000a, 0);
    wr(2, 17'h0005c, 0);
    wr(3, 17'h03777, 0);
    chk(cfg_q[0], 17'h03777);
    wr(3, 17'h13777, 0);
    wr(3, 17'h18000, 1);
    plus_mv = 24'h001064;
    wr(0, 17'h00005, 0);
    chk({ctrl_q, dbl}, 4'ha);
    tick(1);
    chk({act, rdy}, 4'hc);
    wr(1, 17'h00003, 0);
    wr(3, 17'h10000, 0);
    chk({evt_q, cfg_q[0]}, {4'ha, 17'h13777});
    wait_rdy(0);
    tick(4);
    chk(res[0], 1'b1);
    minus_mv = 24'h0000c8;
    tick(4);
    chk(res[0], 1'b0);
    wait_rdy(1);
    chk(res[1], 1'b0);
    start_req = 2'h2;
    tick(1);
    start_req = 2'h0;
    tick(1);
    chk(res[1], 1'b1);
    plus_mv = 24'h000064;
    tick(4);
    chk(res[1], 1'b1);
    wr(0, 17'h00001, 0);
    tick(1);
    chk({act, cfg_q[0].enable, cfg_q[1].enable}, 4'h3);
    wr(0, 17'h00004, 0);
    tick(1);
    wait_rdy(0);
    chk(24'(n >= ace_pkg::DOUBLER_EXTRA_CYC), 24'h1);
    clk_en = 1'b0;
    wr(0, 17'h00001, 0);
    chk({ctrl_q, rdy[0]}, 4'h9);
    clk_en = 1'b1;
    wr(0, 17'h00007, 0);
    tick(1);
    chk({ctrl_q, evt_q, dbg_q, act}, {3'h0, ace_pkg::EVT_RST, 8'h5c, 2'h0});
    chk(cfg_q[0], ace_pkg::CFG_RST);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
